// [psb_pkg.sv]
// Shared constants for the pseudo-static RAM burst link
package psb_pkg;

  // ********************************************************
  // Link widths
  // ********************************************************
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;

  // ********************************************************
  // Timing figures
  // ********************************************************
  localparam int CLK_PERIOD_NS    = 10;
  localparam int BEADV_NS         = 7;
  localparam int BSADV_NS         = 12;
  localparam int BURST_MAX_NS     = 2500;
  localparam int CLK_MIN_PERIOD_NS = 15;
  localparam int CLK_MAX_PERIOD_NS = 200;
  localparam int BEADV_CYC  = (BEADV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BSADV_CYC  = (BSADV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BURST_MAX_CYC = BURST_MAX_NS / CLK_PERIOD_NS;
  // Link clock divider: half period in system cycles, full period >= 15 ns
  localparam int LCLK_HALF_CYC =
    (CLK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);

  // ********************************************************
  // Defaults after reset, and counter width
  // ********************************************************
  localparam int LATENCY_DEF = 5;
  localparam int BURST_LEN_DEF = 4;
  localparam int CNT_W = 12;

endpackage : psb_pkg

// [psb_link_if.sv]
// Interface carrying the burst link pins between controller and RAM
`timescale 1ns/1ps
interface psb_link_if;
  logic                     link_clk;
  logic                     chip_select_n;
  logic                     address_valid_n;
  logic                     write_enable_n;
  logic                     output_enable_n;
  logic                     upper_byte_enable_n;
  logic                     lower_byte_enable_n;
  logic [psb_pkg::ADDR_W-1:0] addr;
  logic [psb_pkg::DATA_W-1:0] dq_host;
  logic                     dq_host_oe;
  logic [psb_pkg::DATA_W-1:0] dq_ram;
  logic                     dq_ram_oe;
  logic                     wait_n;
  logic                     wait_oe;

  modport host (
    output link_clk, chip_select_n, address_valid_n, write_enable_n, output_enable_n,
    output upper_byte_enable_n, lower_byte_enable_n, addr, dq_host, dq_host_oe,
    input  dq_ram, dq_ram_oe, wait_n, wait_oe
  );
  modport ram (
    input  link_clk, chip_select_n, address_valid_n, write_enable_n, output_enable_n,
    input  upper_byte_enable_n, lower_byte_enable_n, addr, dq_host, dq_host_oe,
    output dq_ram, dq_ram_oe, wait_n, wait_oe
  );
endinterface : psb_link_if

// [psb_ram.sv]
// RAM end of the synchronous burst link
`timescale 1ns/1ps
module psb_ram
  import psb_pkg::*;
#(
  parameter int DEPTH_W = 10
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 reset_n_in,
  psb_link_if.ram                   link,
  input  wire logic [3:0]           latency_in,
  output logic                      burst_active_out,
  output logic                      burst_write_out
);
  import psb_pkg::*;

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [DATA_W-1:0] dq_s1_q;
  logic [DATA_W-1:0] dq_s2_q;
  logic [ADDR_W-1:0] a_s1_q;
  logic [ADDR_W-1:0] a_s2_q;
  logic [1:0]        be_s1_q;
  logic [1:0]        be_s2_q;

  always_ff @(posedge clk_sys_in)
  begin
    sync1_q <= {link.link_clk, link.chip_select_n, link.address_valid_n,
                link.write_enable_n, link.output_enable_n};
    sync2_q <= sync1_q;
    dq_s1_q <= link.dq_host;
    dq_s2_q <= dq_s1_q;
    a_s1_q  <= link.addr;
    a_s2_q  <= a_s1_q;
    be_s1_q <= {link.upper_byte_enable_n, link.lower_byte_enable_n};
    be_s2_q <= be_s1_q;
  end

  logic lclk_s;
  logic cs_n_s;
  logic adv_n_s;
  logic we_n_s;
  logic oe_n_s;
  assign {lclk_s, cs_n_s, adv_n_s, we_n_s, oe_n_s} = sync2_q;

  logic lclk_d_q;
  logic cs_d_q;
  logic adv_d_q;
  logic started_q;
  logic rise;
  logic cs_fall;
  logic adv_fall;
  assign rise     = lclk_s & ~lclk_d_q;
  assign cs_fall  = ~cs_n_s & cs_d_q;
  assign adv_fall = ~adv_n_s & adv_d_q;

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      lclk_d_q <= 1'b0;
      cs_d_q   <= 1'b1;
      adv_d_q  <= 1'b1;
    end
    else
    begin
      lclk_d_q <= lclk_s;
      cs_d_q   <= cs_n_s;
      adv_d_q  <= adv_n_s;
    end
  end

  // ********************************************************
  // Burst state
  // ********************************************************
  logic [3:0]         lat_q;
  logic [DEPTH_W-1:0] ptr_q;
  logic               go;
  logic               data_phase;
  logic [DATA_W-1:0]  mem [0:(1<<DEPTH_W)-1];

  // Only the first rising edge with address-valid low opens a burst
  assign go = rise & ~cs_n_s & ~adv_n_s & ~started_q;
  assign data_phase = burst_active_out & (lat_q == 4'h0);

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in || cs_n_s)
      started_q <= 1'b0;
    else if (go)
      started_q <= 1'b1;
    else if (adv_n_s)
      started_q <= 1'b0;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in || cs_n_s)
    begin
      burst_active_out <= 1'b0;
      burst_write_out  <= 1'b0;
      lat_q            <= 4'h0;
      ptr_q            <= '0;
    end
    else if (go)
    begin
      burst_active_out <= 1'b1;
      burst_write_out  <= ~we_n_s;
      lat_q            <= latency_in;
      ptr_q            <= a_s2_q[DEPTH_W-1:0];
    end
    else if (rise && burst_active_out)
    begin
      if (lat_q != 4'h0)
        lat_q <= lat_q - 4'h1;
      else
        ptr_q <= ptr_q + 1'b1;
    end
  end

  // Byte lanes masked by the enables during a write
  always_ff @(posedge clk_sys_in)
  begin
    if (rise && data_phase && burst_write_out)
    begin
      if (!be_s2_q[0])
        mem[ptr_q][7:0] <= dq_s2_q[7:0];
      if (!be_s2_q[1])
        mem[ptr_q][15:8] <= dq_s2_q[15:8];
    end
  end

  // ********************************************************
  // Wait and data drive
  // ********************************************************
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in || cs_n_s)
    begin
      link.wait_oe <= 1'b0;
      link.wait_n  <= 1'b1;
    end
    else if (cs_fall || adv_fall)
    begin
      link.wait_oe <= 1'b1;
      link.wait_n  <= 1'b0;
    end
    else if (rise && burst_active_out && lat_q == 4'h1)
      link.wait_n  <= 1'b1;
  end

  // Read data driven at each rising edge from the last latency clock on while output enable and at least one byte enable are low
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in || cs_n_s || oe_n_s || &be_s2_q)
    begin
      link.dq_ram_oe <= 1'b0;
      link.dq_ram    <= '0;
    end
    else if (rise && burst_active_out && !burst_write_out && lat_q <= 4'h1)
    begin
      link.dq_ram_oe <= 1'b1;
      link.dq_ram    <= mem[lat_q == 4'h0 ? ptr_q + 1'b1 : ptr_q];
    end
  end

endmodule : psb_ram

// [psb_host.sv]
// Controller end of the synchronous burst link
`timescale 1ns/1ps
module psb_host
  import psb_pkg::*;
#(
  parameter int BURST_MAX = BURST_MAX_CYC
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 reset_n_in,
  psb_link_if.host                  link,
  input  wire logic                 req_valid_in,
  output logic                      req_ready_out,
  input  wire logic                 req_write_in,
  input  wire logic                 req_stop_in,
  input  wire logic [ADDR_W-1:0]    req_addr_in,
  input  wire logic [DATA_W-1:0]    req_wdata_in,
  input  wire logic [3:0]           req_latency_in,
  output logic                      rd_valid_out,
  input  wire logic                 rd_ready_in,
  output logic [DATA_W-1:0]         rd_data_out
);
  import psb_pkg::*;

  // ********************************************************
  // Link clock divider, period stays inside the legal range
  // ********************************************************
  logic [3:0] div_q;
  logic       rise_en;
  assign rise_en = (div_q == 4'(LCLK_HALF_CYC - 1)) & ~link.link_clk;

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      div_q         <= 4'h0;
      link.link_clk <= 1'b0;
    end
    else if (div_q == 4'(LCLK_HALF_CYC - 1))
    begin
      div_q         <= 4'h0;
      link.link_clk <= ~link.link_clk;
    end
    else
      div_q <= div_q + 4'h1;
  end

  // ********************************************************
  // Two-entry read buffer
  // ********************************************************
  logic [DATA_W-1:0] buf_q [0:1];
  logic [1:0] cnt_q;
  logic       wr_ptr_q;
  logic       rd_ptr_q;
  logic       push;
  logic       pop;
  logic [DATA_W-1:0] dq_s1_q;
  logic [DATA_W-1:0] dq_s2_q;
  logic              wt1_q;
  logic              wt2_q;
  assign pop = rd_valid_out & rd_ready_in;

  always_ff @(posedge clk_sys_in)
  begin
    dq_s1_q <= link.dq_ram;
    dq_s2_q <= dq_s1_q;
    // A released wait pin reads as not ready
    wt1_q   <= link.wait_n & link.wait_oe;
    wt2_q   <= wt1_q;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      cnt_q    <= 2'h0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        buf_q[wr_ptr_q] <= dq_s2_q;
        wr_ptr_q        <= ~wr_ptr_q;
      end
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      rd_valid_out <= 1'b0;
      rd_data_out  <= '0;
    end
    else
    begin
      rd_valid_out <= (cnt_q + {1'b0, push} - {1'b0, pop}) != 2'h0;
      rd_data_out  <= (pop || cnt_q == 2'h0) ? (cnt_q == 2'h2 ? buf_q[~rd_ptr_q] : dq_s2_q)
                                              : buf_q[rd_ptr_q];
    end
  end

  // ********************************************************
  // Burst sequencer
  // ********************************************************
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_GAP   = 4'b1000
  } psb_state_type;

  psb_state_type st_q;
  logic [CNT_W-1:0] tbc_q;
  logic [3:0]       lat_q;
  logic [3:0]       gap_q;
  logic             full;
  assign full = (cnt_q == 2'h2);
  // A read stalls while the buffer has no room, which closes the burst
  assign push = rise_en && st_q == ST_DATA && !link.write_enable_n == 1'b0
                && lat_q == 4'h0 && wt2_q && !full;

  // The RAM cannot be paused, so a full buffer closes the burst and a later
  // burst resumes at the first word that found no room
  logic [ADDR_W-1:0] next_addr_q;
  logic              resume_q;
  logic              stall;
  assign stall = rise_en && st_q == ST_DATA && link.write_enable_n
                 && lat_q == 4'h0 && wt2_q && full;

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      next_addr_q <= '0;
      resume_q    <= 1'b0;
    end
    else
    begin
      if (st_q == ST_IDLE && req_valid_in && rise_en && !full && !resume_q)
        next_addr_q <= req_addr_in;
      else if (push)
        next_addr_q <= next_addr_q + 1'b1;
      if (stall)
        resume_q <= 1'b1;
      else if (!req_valid_in)
        resume_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      st_q                     <= ST_IDLE;
      req_ready_out            <= 1'b0;
      link.chip_select_n       <= 1'b1;
      link.address_valid_n     <= 1'b1;
      link.write_enable_n      <= 1'b1;
      link.output_enable_n     <= 1'b1;
      link.upper_byte_enable_n <= 1'b1;
      link.lower_byte_enable_n <= 1'b1;
      link.addr                <= '0;
      link.dq_host             <= '0;
      link.dq_host_oe          <= 1'b0;
      tbc_q                    <= '0;
      lat_q                    <= 4'h0;
      gap_q                    <= 4'h0;
    end
    else
    begin
      req_ready_out <= 1'b0;
      unique case (st_q)
        ST_IDLE:
          if (req_valid_in && rise_en && !full)
          begin
            link.chip_select_n   <= 1'b0;
            link.address_valid_n <= 1'b0;
            link.addr            <= resume_q ? next_addr_q : req_addr_in;
            link.write_enable_n  <= ~req_write_in;
            lat_q                <= req_latency_in;
            tbc_q                <= '0;
            st_q                 <= ST_START;
          end
        ST_START:
          if (rise_en)
          begin
            link.address_valid_n <= 1'b1;
            // This edge is the first latency clock after the command clock
            if (lat_q != 4'h0)
              lat_q <= lat_q - 4'h1;
            // Byte enables, and output enable on a read, go low right away, well ahead of the last latency clock
            link.output_enable_n     <= link.write_enable_n ? 1'b0 : 1'b1;
            link.upper_byte_enable_n <= 1'b0;
            link.lower_byte_enable_n <= 1'b0;
            st_q                     <= ST_DATA;
          end
        ST_DATA:
        begin
          tbc_q <= tbc_q + 1'b1;
          if (rise_en && lat_q != 4'h0)
            lat_q <= lat_q - 4'h1;
          if (rise_en && lat_q == 4'h0)
          begin
            req_ready_out   <= 1'b1;
            link.dq_host    <= req_wdata_in;
            link.dq_host_oe <= ~link.write_enable_n;
          end
          // Burst ends on request stop, stall or dropped request, or once tbc_q reaches the maximum burst time less one link clock period
          if (req_stop_in || stall || !req_valid_in
              || tbc_q >= CNT_W'(BURST_MAX - 2 * LCLK_HALF_CYC))
          begin
            link.chip_select_n       <= 1'b1;
            link.output_enable_n     <= 1'b1;
            link.upper_byte_enable_n <= 1'b1;
            link.lower_byte_enable_n <= 1'b1;
            link.dq_host_oe          <= 1'b0;
            gap_q <= (req_stop_in || stall) ? 4'(BSADV_CYC) : 4'(BEADV_CYC);
            st_q  <= ST_GAP;
          end
        end
        ST_GAP:
          if (gap_q != 4'h0)
            gap_q <= gap_q - 4'h1;
          else
            st_q <= ST_IDLE;
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

endmodule : psb_host

// [psb_link_sva.sv]
// Concurrent checks on the burst link pins between controller and RAM
`timescale 1ns/1ps
module psb_link_sva
  import psb_pkg::*;
#(
  parameter int BURST_MAX = 80
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic link_clk,
  input wire logic chip_select_n,
  input wire logic address_valid_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic upper_byte_enable_n,
  input wire logic lower_byte_enable_n,
  input wire logic dq_ram_oe,
  input wire logic wait_n,
  input wire logic wait_oe
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);
  // ****************************************
  // Helper state
  // ****************************************
  logic [CNT_W-1:0] lo_cnt_q;
  logic             rd_q;
  // Burst length counted from start, so a held select still restarts it
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in || chip_select_n || $fell(address_valid_n))
      lo_cnt_q <= '0;
    else
      lo_cnt_q <= lo_cnt_q + 1'b1;
  end
  // Write-enable can move after the start edge, so latch the burst kind
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
      rd_q <= 1'b0;
    else if (!address_valid_n)
      rd_q <= write_enable_n;
  end
  a_wait_low_start: assert property (
    $fell(address_valid_n) |-> ##[1:6] (wait_oe && !wait_n))
    else $error("wait not pulled low after burst start");
  a_wait_high_lat: assert property (
    $fell(address_valid_n) |-> ##[8:60] (wait_oe && wait_n))
    else $error("wait not raised before latency end");
  a_wait_release: assert property (
    $rose(chip_select_n) |-> ##[0:3] !wait_oe)
    else $error("wait still driven after deselect");
  a_wait_idle_off: assert property (
    chip_select_n [*5] |-> !wait_oe)
    else $error("wait driven while deselected");
  a_read_enables: assert property (
    $rose(wait_n) && wait_oe && rd_q |->
      !output_enable_n && !upper_byte_enable_n && !lower_byte_enable_n)
    else $error("read enables late");
  a_dq_needs_oe: assert property (
    $rose(dq_ram_oe) |-> !output_enable_n && !chip_select_n)
    else $error("data driven without output enable");
  a_adv_single: assert property (
    $fell(address_valid_n) |-> ##[1:12] address_valid_n)
    else $error("address valid held low too long");
  a_burst_gap: assert property (
    $rose(chip_select_n) |=> address_valid_n)
    else $error("new burst without gap");
  a_burst_max: assert property (
    lo_cnt_q <= CNT_W'(BURST_MAX + 2))
    else $error("burst too long");
  a_lclk_high: assert property (
    $rose(link_clk) |-> ##[2:20] $rose(link_clk))
    else $error("link clock period out of range");
  a_lclk_low: assert property (
    $fell(link_clk) |-> ##[1:10] $rose(link_clk))
    else $error("link clock low phase too long");
endmodule : psb_link_sva

// [test_psram_sync_burst_interface.sv]
// Bench joining the controller and RAM ends over the burst link
`timescale 1ns/1ps
module test_psram_sync_burst_interface;
  import psb_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int BMAX = 80;
  logic              clk_sys_in;
  logic              reset_n_in;
  logic              req_valid_in;
  logic              req_write_in;
  logic              req_stop_in;
  logic              rd_ready_in;
  logic [ADDR_W-1:0] req_addr_in;
  logic [DATA_W-1:0] req_wdata_in;
  logic [3:0]        req_latency_in;
  logic [3:0]        latency_in;
  logic              req_ready_out;
  logic              rd_valid_out;
  logic [DATA_W-1:0] rd_data_out;
  logic              burst_active_out;
  logic              burst_write_out;
  int                fail_count = 0;
  int                n_tests = 0;
  int                act_rises = 0;
  int                adv_falls = 0;
  psb_link_if lk ();
  psb_host #(.BURST_MAX(BMAX)) u_psb_host (.clk_sys_in, .reset_n_in, .link(lk.host),
    .req_valid_in, .req_ready_out, .req_write_in, .req_stop_in, .req_addr_in,
    .req_wdata_in, .req_latency_in, .rd_valid_out, .rd_ready_in, .rd_data_out);
  psb_ram u_psb_ram (.clk_sys_in, .reset_n_in, .link(lk.ram), .latency_in,
    .burst_active_out, .burst_write_out);
  psb_link_sva #(.BURST_MAX(BMAX)) u_psb_link_sva (.clk_sys_in, .reset_n_in,
    .link_clk(lk.link_clk), .chip_select_n(lk.chip_select_n),
    .address_valid_n(lk.address_valid_n), .write_enable_n(lk.write_enable_n),
    .output_enable_n(lk.output_enable_n), .upper_byte_enable_n(lk.upper_byte_enable_n),
    .lower_byte_enable_n(lk.lower_byte_enable_n), .dq_ram_oe(lk.dq_ram_oe),
    .wait_n(lk.wait_n), .wait_oe(lk.wait_oe));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge burst_active_out) act_rises++;
  always @(negedge lk.address_valid_n) adv_falls++;
  function automatic bit tst(input bit c);
    n_tests++;
    return c;
  endfunction : tst
  task automatic bad(input string m);
    fail_count++;
    $display("wrong value at %0t ns: %s", $time, m);
  endtask : bad
  task automatic wait_idle();
    int i;
    for (i = 0; i < 300 && !(burst_active_out === 1'b0 && lk.chip_select_n === 1'b1); i++)
      @(negedge clk_sys_in);
    if (!tst(i < 300)) bad("burst did not end");
    repeat (4) @(negedge clk_sys_in);
  endtask : wait_idle
  // Each slot pulse is waited for afresh, so one pulse is never counted twice
  task automatic do_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] b, input int n);
    int k;
    int i;
    req_write_in = 1'b1;
    req_addr_in = a;
    req_wdata_in = b;
    req_valid_in = 1'b1;
    for (k = 0; k < n; k++)
    begin
      i = 0;
      do
      begin
        @(posedge clk_sys_in) #1;
        i++;
      end while (i < 200 && req_ready_out !== 1'b1);
      if (!tst(i < 200)) bad("write slot missing");
      @(negedge clk_sys_in);
      if (!tst(burst_write_out === 1'b1)) bad("burst kind not write");
      req_wdata_in = b + DATA_W'(k + 1);
    end
    req_valid_in = 1'b0;
    wait_idle();
  endtask : do_write
  task automatic do_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] b, input int n,
                         input int stall);
    int k;
    int t;
    req_write_in = 1'b0;
    req_addr_in = a;
    req_valid_in = 1'b1;
    rd_ready_in = 1'b0;
    k = 0;
    for (t = 0; t < 600 && k < n; t++)
    begin
      @(negedge clk_sys_in);
      rd_ready_in = (t >= stall);
      if (t == stall && stall > 0 && !tst(rd_valid_out === 1'b1)) bad("word lost in stall");
      if (rd_valid_out === 1'b1 && rd_ready_in === 1'b1)
      begin
        if (!tst(rd_data_out === b + DATA_W'(k))) bad("read data");
        if (!tst(burst_write_out === 1'b0)) bad("burst kind not read");
        k++;
      end
    end
    if (!tst(k == n)) bad("read words missing");
    req_valid_in = 1'b0;
    rd_ready_in = 1'b1;
    wait_idle();
  endtask : do_read
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_write_read();
    int r0;
    r0 = act_rises;
    do_write(22'h000100, 16'ha500, 4);
    if (!tst(act_rises == r0 + 1)) bad("write burst restarted");
    do_read(22'h000100, 16'ha500, 4, 0);
    if (!tst(act_rises == r0 + 2)) bad("read burst restarted");
  endtask : test_write_read
  task automatic test_stall_edge();
    do_write(22'h3ffffc, 16'h5a00, 3);
    do_read(22'h3ffffc, 16'h5a00, 3, 32);
  endtask : test_stall_edge
  task automatic test_stop();
    int i;
    req_write_in = 1'b0;
    req_addr_in = 22'h000100;
    req_valid_in = 1'b1;
    for (i = 0; i < 300 && rd_valid_out !== 1'b1; i++)
      @(negedge clk_sys_in);
    req_stop_in = 1'b1;
    @(negedge clk_sys_in);
    req_stop_in = 1'b0;
    for (i = 0; i < 300 && lk.address_valid_n !== 1'b0; i++)
      @(negedge clk_sys_in);
    if (!tst(i >= BSADV_CYC && i < 300)) bad("stop gap");
    // Let the restarted burst pass its latency before it is closed
    repeat (40) @(negedge clk_sys_in);
    req_valid_in = 1'b0;
    wait_idle();
  endtask : test_stop
  task automatic test_long();
    int c0;
    c0 = adv_falls;
    do_write(22'h000200, 16'h0c00, 60);
    if (!tst(adv_falls >= c0 + 2)) bad("long burst not split");
  endtask : test_long
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial
  begin
    reset_n_in = 1'b0;
    req_valid_in = 1'b0;
    req_write_in = 1'b0;
    req_stop_in = 1'b0;
    rd_ready_in = 1'b1;
    req_addr_in = '0;
    req_wdata_in = '0;
    req_latency_in = 4'(LATENCY_DEF);
    latency_in = 4'(LATENCY_DEF);
    // Held two cycles; pin synchronisers settle before the first request
    repeat (2) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    test_write_read();
    test_stall_edge();
    test_stop();
    test_long();
    print_verdict();
  end
  initial
  begin
    #300000;
    fail_count++;
    print_verdict();
  end
endmodule : test_psram_sync_burst_interface
